// ===== src/fsp_top.sv
`timescale 1ns/100ps
`include "fsp_consts.svh"
// Function
// - Access-select bit routes mode-register writes and reads to copy 0 or 1.
// - Operating-select bit chooses which copy governs device operation.
// - Access and operating selects are independent; writing idle copy keeps operation.
// - Switch completes within 200 ns, or 250 ns on a range change.
// - After reset operation uses copy 0; both copies hold low-frequency defaults.
// - Write leveling entered by writing leveling bit one, left by zero.
// - On leveling entry data outputs are undefined until feedback exists.
// - Rising strobe samples clock; level drives the byte of that strobe.
// - Each strobe is leveled independently; one channel here.
// - Every rising strobe edge overwrites the captured level on all bits of its byte.
// - Feedback appears within the leveling output delay after the strobe edge.
// - A switch applies all parameters of the new copy together.
module fsp_top
   import fsp_pkg::*;
(
   // Clock and reset
   input  wire logic              REF_CLK,
   input  wire logic              RST_B,
   // AXI4-Lite write address
   input  wire fsp_pkg::fsp_addr_t S_AXI_AWADDR,
   input  wire logic              S_AXI_AWVALID,
   output wire logic              S_AXI_AWREADY,
   // AXI4-Lite write data
   input  wire logic [31:0]       S_AXI_WDATA,
   input  wire logic [3:0]        S_AXI_WSTRB,
   input  wire logic              S_AXI_WVALID,
   output wire logic              S_AXI_WREADY,
   // AXI4-Lite write response
   output wire logic [1:0]        S_AXI_BRESP,
   output wire logic              S_AXI_BVALID,
   input  wire logic              S_AXI_BREADY,
   // AXI4-Lite read
   input  wire fsp_pkg::fsp_addr_t S_AXI_ARADDR,
   input  wire logic              S_AXI_ARVALID,
   output wire logic              S_AXI_ARREADY,
   output wire logic [31:0]       S_AXI_RDATA,
   output wire logic [1:0]        S_AXI_RRESP,
   output wire logic              S_AXI_RVALID,
   input  wire logic              S_AXI_RREADY,
   // Link pins
   input  wire logic              CK_T,
   input  wire logic [1:0]        DQS_T,
   output wire logic [15:0]       DQ_O,
   output wire logic [15:0]       DQ_OE,
   // Status
   output wire logic              SET_POINT_OPERATING,
   output wire logic              SET_POINT_SWITCHING,
   output wire logic              VREF_CURRENT_MODE,
   output wire logic              WL_ACTIVE
);
   import fsp_pkg::*;

   fsp_byte_t  dup_q [2][`FSP_NDUP];
   fsp_byte_t  mode_register_thirteen_q;
   logic       wl_q;
   logic       act_sel_q;
   fsp_tmr_t   tmr_q;
   logic       aw_have_q;
   logic       w_have_q;
   fsp_addr_t  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic       bvalid_q;
   logic [1:0] bresp_q;
   logic       rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [13:0] mrw_q;
   fsp_ma_t    mrr_sel_q;

   fsp_wl_if wl ();

   // Bus decode
   wire        aw_hs    = S_AXI_AWVALID & S_AXI_AWREADY;
   wire        w_hs     = S_AXI_WVALID & S_AXI_WREADY;
   wire        ar_hs    = S_AXI_ARVALID & S_AXI_ARREADY;
   wire        wr_go    = aw_have_q & w_have_q & ~bvalid_q;
   wire        wr_mrw   = awaddr_q[4:2] == `FSP_A_MRW >> 2;
   wire        wr_sel   = awaddr_q[4:2] == `FSP_A_MRR_SEL >> 2;
   wire        wr_ok    = wr_mrw | wr_sel;
   wire        mrw_go   = wr_go & wr_mrw & wstrb_q[0];
   wire        sel_go   = wr_go & wr_sel & wstrb_q[0];
   wire [2:0]  ar_word  = S_AXI_ARADDR[4:2];
   wire        rd_ok    = ar_word <= `FSP_A_ACTIVE >> 2;

   // Mode-register command decode
   wire [5:0]  cmd_ma   = wstrb_q[1] ? wdata_q[13:8] : mrw_q[13:8];
   wire fsp_byte_t cmd_op = wdata_q[7:0];
   wire        cmd_dup  = fsp_dup_hit(cmd_ma);
   wire fsp_idx_t cmd_idx = fsp_dup_idx(cmd_ma);
   wire        acc_sel  = mode_register_thirteen_q[`FSP_MODE_REGISTER_THIRTEEN_ACC];
   wire        op_req   = mode_register_thirteen_q[`FSP_MODE_REGISTER_THIRTEEN_OP];
   wire        busy     = tmr_q != 5'h00;
   wire        mode_register_thirteen_go  = mrw_go & cmd_ma == `FSP_MA_MODE_REGISTER_THIRTEEN;
   wire        op_flip  = mode_register_thirteen_go & (cmd_op[`FSP_MODE_REGISTER_THIRTEEN_OP] != op_req);
   wire fsp_idx_t idx12 = fsp_dup_idx(`FSP_MA_MODE_REGISTER_TWELVE);
   wire fsp_idx_t idx2  = fsp_dup_idx(`FSP_MA_MR2);

   // Class is judged from both command reference copies at the switch write
   wire fsp_tfc_e tfc_cls = fsp_tfc_class(dup_q[0][idx12], dup_q[1][idx12]);
   wire fsp_tmr_t tfc_len = fsp_tfc_cycles(tfc_cls);

   // Readback paths
   wire        rd_dup   = fsp_dup_hit(mrr_sel_q);
   wire fsp_idx_t rd_idx = fsp_dup_idx(mrr_sel_q);
   wire fsp_byte_t rd_dupv = dup_q[acc_sel][rd_idx];
   wire        rd_is2   = mrr_sel_q == `FSP_MA_MR2;
   wire        rd_is13  = mrr_sel_q == `FSP_MA_MODE_REGISTER_THIRTEEN;
   wire fsp_byte_t mrr_data = rd_dup ? (rd_is2 ? {wl_q, rd_dupv[6:0]} : rd_dupv) :
                              rd_is13 ? mode_register_thirteen_q : 8'h00;
   wire fsp_byte_t act_mode_register_twelve = dup_q[act_sel_q][idx12];
   wire fsp_byte_t act_mr2  = dup_q[act_sel_q][idx2];
   wire [31:0] status_w = {25'h0, wl.fb_vld, wl_q, mode_register_thirteen_q[`FSP_MODE_REGISTER_THIRTEEN_VREF_CURRENT_MODE], busy, op_req, act_sel_q};
   wire [31:0] active_w = {16'h0, act_mr2, act_mode_register_twelve};
   wire [31:0] rd_mux   = ar_word == 3'h0 ? {18'h0, mrw_q} :
                          ar_word == 3'h1 ? {26'h0, mrr_sel_q} :
                          ar_word == 3'h2 ? {24'h0, mrr_data} :
                          ar_word == 3'h3 ? status_w :
                          ar_word == 3'h4 ? active_w : 32'h0;

   assign S_AXI_AWREADY = ~aw_have_q & ~bvalid_q;
   assign S_AXI_WREADY  = ~w_have_q & ~bvalid_q;
   assign S_AXI_BVALID  = bvalid_q;
   assign S_AXI_BRESP   = bresp_q;
   assign S_AXI_ARREADY = ~rvalid_q;
   assign S_AXI_RVALID  = rvalid_q;
   assign S_AXI_RDATA   = rdata_q;
   assign S_AXI_RRESP   = rresp_q;

   // Write channel: address and data may arrive in either order
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= 5'h00;
         wdata_q   <= 32'h0;
         wstrb_q   <= 4'h0;
      end else begin
         if (aw_hs) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= S_AXI_AWADDR;
         end else if (wr_go) begin
            aw_have_q <= 1'b0;
         end
         if (w_hs) begin
            w_have_q <= 1'b1;
            wdata_q  <= S_AXI_WDATA;
            wstrb_q  <= S_AXI_WSTRB;
         end else if (wr_go) begin
            w_have_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `FSP_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_ok ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read data is registered one cycle after the address is taken
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0;
         rresp_q  <= `FSP_RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_ok ? rd_mux : 32'h0;
         rresp_q  <= rd_ok ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
         rvalid_q <= 1'b0;
      end
   end

   // Command register mirrors the last command; the read selector is separate
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         mrw_q     <= 14'h0;
         mrr_sel_q <= 6'h00;
      end else begin
         if (mrw_go) begin
            mrw_q <= {cmd_ma, cmd_op};
         end
         if (sel_go) begin
            mrr_sel_q <= wdata_q[5:0];
         end
      end
   end

   // Duplicated copies: a write lands only in the access-selected copy
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < `FSP_NDUP; i++) begin
               dup_q[c][i] <= `FSP_DUP_RST;
            end
            dup_q[c][4] <= `FSP_VREF_RST;
            dup_q[c][5] <= `FSP_VREF_RST;
         end
      end else if (mrw_go && cmd_dup) begin
         dup_q[acc_sel][cmd_idx] <= cmd_op & (cmd_ma == `FSP_MA_MR2 ? 8'h7F : 8'hFF);
      end
   end

   // Leveling bit is a single register outside the copies
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         wl_q <= 1'b0;
      end else if (mrw_go && cmd_ma == `FSP_MA_MR2) begin
         wl_q <= cmd_op[`FSP_MR2_WL];
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         mode_register_thirteen_q <= `FSP_MODE_REGISTER_THIRTEEN_RST;
      end else if (mode_register_thirteen_go) begin
         mode_register_thirteen_q <= cmd_op;
      end
   end

   // Switch timer: the operating copy changes in one step at expiry, so no
   // parameter of the new copy can be seen ahead of the others; a reversal
   // while busy restarts the count toward the newly requested copy
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         tmr_q     <= 5'h00;
         act_sel_q <= 1'b0;
      end else if (op_flip) begin
         tmr_q <= tfc_len;
      end else if (busy) begin
         tmr_q <= tmr_q - 5'h01;
         if (tmr_q == 5'h01) begin
            act_sel_q <= op_req;
         end
      end
   end

   // Cycles since the latest switch request, saturating; the switch-time
   // checks below span more cycles than a repetition may count
   fsp_tmr_t   sw_age_q;

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         sw_age_q <= 5'h00;
      end else if (op_flip) begin
         sw_age_q <= 5'h00;
      end else if (sw_age_q != 5'h1F) begin
         sw_age_q <= sw_age_q + 5'h01;
      end
   end

   fsp_wl_capture u_cap (
      .clk     (REF_CLK),
      .rst_b   (RST_B),
      .ck_pin  (CK_T),
      .dqs_pin (DQS_T),
      .wl      (wl.capture)
   );

   assign wl.en = wl_q;

   // Feedback fans out to all bits of each byte; value before the first
   // capture is zero, which the controller must treat as meaningless
   assign DQ_O  = {{8{wl.fb[1]}}, {8{wl.fb[0]}}};
   assign DQ_OE = {16{wl_q}};
   assign SET_POINT_OPERATING = act_sel_q;
   assign SET_POINT_SWITCHING = busy;
   assign VREF_CURRENT_MODE   = mode_register_thirteen_q[`FSP_MODE_REGISTER_THIRTEEN_VREF_CURRENT_MODE];
   assign WL_ACTIVE           = wl_q;

   localparam int TFC_MAX = `FSP_TFC_LONG_CYC;
   localparam int TFC_MIN = `FSP_TFC_SHORT_CYC;

   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);

   sequence s_switch_req;
      op_flip && !busy;
   endsequence
   sequence s_switch_held;
      $stable(act_sel_q) [*8];
   endsequence

   a_acc_route: assert property (mrw_go && cmd_dup && cmd_ma != `FSP_MA_MR2
      |=> dup_q[$past(acc_sel)][$past(cmd_idx)] == $past(cmd_op))
      else $error("write missed the access-selected copy");
   a_idle_copy_safe: assert property (mrw_go && cmd_dup && acc_sel != act_sel_q && !busy
      |=> $stable(act_mode_register_twelve) && $stable(act_mr2))
      else $error("idle copy write disturbed operation");
   a_switch_hold: assert property (s_switch_req |=> s_switch_held)
      else $error("operating copy changed too early");
   a_switch_done: assert property ($fell(busy)
      |-> act_sel_q == op_req && sw_age_q >= 5'(TFC_MIN) && sw_age_q <= 5'(TFC_MAX))
      else $error("switch not complete within switch time");
   a_switch_bound: assert property (busy |-> sw_age_q < 5'(TFC_MAX))
      else $error("switch ran past the long switch time");
   a_copy_atomic: assert property ($changed(SET_POINT_OPERATING) |-> $past(tmr_q) == 5'h01)
      else $error("operating copy changed outside timer expiry");
   a_acc_no_switch: assert property (mode_register_thirteen_go && !op_flip && !busy |=> !busy && $stable(act_sel_q))
      else $error("access-select write disturbed operation");
   a_long_class: assert property (op_flip && tfc_cls == FSP_TFC_LONG |=> tmr_q == 5'(TFC_MAX))
      else $error("range change not given the long switch time");
   a_wl_entry: assert property (mrw_go && cmd_ma == `FSP_MA_MR2
      |=> WL_ACTIVE == $past(cmd_op[`FSP_MR2_WL]) && DQ_OE == {16{WL_ACTIVE}})
      else $error("leveling mode did not follow the command");
   // Pins stay quiet one cycle after exit, once the capture has cleared
   a_dq_idle: assert property (!WL_ACTIVE && !$past(WL_ACTIVE)
      |-> DQ_O == 16'h0000 && DQ_OE == 16'h0000)
      else $error("data pins active outside leveling");
   // Feedback reaches its byte once the capture has registered it
   a_fb_latency: assert property (wl.cap[0] && WL_ACTIVE ##1 WL_ACTIVE
      |-> DQ_O[7:0] == {8{wl.fb[0]}} && wl.fb_vld[0])
      else $error("strobe 0 feedback late on its byte");
   a_fb_byte_one: assert property (wl.cap[1] && WL_ACTIVE ##1 WL_ACTIVE
      |-> DQ_O[15:8] == {8{wl.fb[1]}} && wl.fb_vld[1])
      else $error("strobe 1 feedback late on its byte");
   a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write response dropped early");
endmodule : fsp_top

// ===== src/fsp_consts.svh
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH
// Register byte offsets on the AXI4-Lite bus
`define FSP_A_MRW        5'h00
`define FSP_A_MRR_SEL    5'h04
`define FSP_A_MRR_DATA   5'h08
`define FSP_A_STATUS     5'h0C
`define FSP_A_ACTIVE     5'h10
// Mode register addresses
`define FSP_MA_MR1       6'h01
`define FSP_MA_MR2       6'h02
`define FSP_MA_MR3       6'h03
`define FSP_MA_MR11      6'h0B
`define FSP_MA_MODE_REGISTER_TWELVE      6'h0C
`define FSP_MA_MODE_REGISTER_THIRTEEN      6'h0D
`define FSP_MA_MR14      6'h0E
`define FSP_MA_MR21      6'h15
`define FSP_MA_MR22      6'h16
`define FSP_MA_MR51      6'h33
`define FSP_NDUP         9
// Field positions
`define FSP_MODE_REGISTER_THIRTEEN_ACC     6
`define FSP_MODE_REGISTER_THIRTEEN_OP      7
`define FSP_MODE_REGISTER_THIRTEEN_VREF_CURRENT_MODE    3
`define FSP_MR2_WL       7
`define FSP_MODE_REGISTER_TWELVE_RANGE   6
// Reset values: unterminated, low-frequency settings in both copies
`define FSP_DUP_RST      8'h00
`define FSP_VREF_RST     8'h4D
`define FSP_MODE_REGISTER_THIRTEEN_RST     8'h00
// Timing
`define FSP_CLK_NS       10
`define FSP_TFC_SHORT_NS 200
`define FSP_TFC_MID_NS   200
`define FSP_TFC_LONG_NS  250
`define FSP_TFC_SHORT_CYC (`FSP_TFC_SHORT_NS / `FSP_CLK_NS)
`define FSP_TFC_MID_CYC   (`FSP_TFC_MID_NS / `FSP_CLK_NS)
`define FSP_TFC_LONG_CYC  (`FSP_TFC_LONG_NS / `FSP_CLK_NS)
// AXI responses
`define FSP_RESP_OKAY    2'h0
`define FSP_RESP_SLVERR  2'h2
`endif

// ===== src/fsp_pkg.sv
package fsp_pkg;
`include "fsp_consts.svh"
   typedef logic [7:0] fsp_byte_t;
   typedef logic [5:0] fsp_ma_t;
   typedef logic [3:0] fsp_idx_t;
   typedef logic [4:0] fsp_addr_t;
   typedef logic [4:0] fsp_tmr_t;
   typedef enum logic [1:0] {FSP_TFC_SHORT, FSP_TFC_MIDDLE, FSP_TFC_LONG} fsp_tfc_e;

   function automatic logic fsp_dup_hit(input fsp_ma_t ma);
      return ma == `FSP_MA_MR1 || ma == `FSP_MA_MR2 || ma == `FSP_MA_MR3 ||
             ma == `FSP_MA_MR11 || ma == `FSP_MA_MODE_REGISTER_TWELVE || ma == `FSP_MA_MR14 ||
             ma == `FSP_MA_MR21 || ma == `FSP_MA_MR22 || ma == `FSP_MA_MR51;
   endfunction : fsp_dup_hit

   function automatic fsp_idx_t fsp_dup_idx(input fsp_ma_t ma);
      case (ma)
         `FSP_MA_MR2:  return 4'h1;
         `FSP_MA_MR3:  return 4'h2;
         `FSP_MA_MR11: return 4'h3;
         `FSP_MA_MODE_REGISTER_TWELVE: return 4'h4;
         `FSP_MA_MR14: return 4'h5;
         `FSP_MA_MR21: return 4'h6;
         `FSP_MA_MR22: return 4'h7;
         `FSP_MA_MR51: return 4'h8;
         default:      return 4'h0;
      endcase
   endfunction : fsp_dup_idx

   // Range change wins over any step count
   function automatic fsp_tfc_e fsp_tfc_class(input fsp_byte_t a, input fsp_byte_t b);
      logic [5:0] d;
      d = (a[5:0] > b[5:0]) ? a[5:0] - b[5:0] : b[5:0] - a[5:0];
      if (a[`FSP_MODE_REGISTER_TWELVE_RANGE] != b[`FSP_MODE_REGISTER_TWELVE_RANGE]) return FSP_TFC_LONG;
      if (d > 6'h01) return FSP_TFC_MIDDLE;
      return FSP_TFC_SHORT;
   endfunction : fsp_tfc_class

   function automatic fsp_tmr_t fsp_tfc_cycles(input fsp_tfc_e c);
      case (c)
         FSP_TFC_LONG:   return 5'(`FSP_TFC_LONG_CYC);
         FSP_TFC_MIDDLE: return 5'(`FSP_TFC_MID_CYC);
         default:        return 5'(`FSP_TFC_SHORT_CYC);
      endcase
   endfunction : fsp_tfc_cycles
endpackage : fsp_pkg

// ===== src/fsp_wl_if.sv
`timescale 1ns/100ps
interface fsp_wl_if;
   logic       en;
   logic [1:0] fb;
   logic [1:0] fb_vld;
   logic [1:0] cap;
   modport top (output en, input fb, input fb_vld, input cap);
   modport capture (input en, output fb, output fb_vld, output cap);
endinterface : fsp_wl_if

// ===== src/fsp_wl_capture.sv
`timescale 1ns/100ps
module fsp_wl_capture (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Pins from the controller
   input  wire logic       ck_pin,
   input  wire logic [1:0] dqs_pin,
   // Leveling link to the top
   fsp_wl_if.capture       wl
);
   logic       ck_s1_q;
   logic       ck_s2_q;
   logic [1:0] dqs_s1_q;
   logic [1:0] dqs_s2_q;
   logic [1:0] dqs_s3_q;
   logic [1:0] fb_q;
   logic [1:0] vld_q;
   wire  [1:0] rise;

   // Clock and strobes share the same synchroniser depth, so their
   // relative phase survives the crossing to within one sample
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ck_s1_q  <= 1'b0;
         ck_s2_q  <= 1'b0;
         dqs_s1_q <= 2'h0;
         dqs_s2_q <= 2'h0;
         dqs_s3_q <= 2'h0;
      end else begin
         ck_s1_q  <= ck_pin;
         ck_s2_q  <= ck_s1_q;
         dqs_s1_q <= dqs_pin;
         dqs_s2_q <= dqs_s1_q;
         dqs_s3_q <= dqs_s2_q;
      end
   end

   assign rise = dqs_s2_q & ~dqs_s3_q & {2{wl.en}};

   // Each strobe captures into its own byte; a newer edge overwrites
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fb_q  <= 2'h0;
         vld_q <= 2'h0;
      end else if (!wl.en) begin
         fb_q  <= 2'h0;
         vld_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (rise[i]) begin
               fb_q[i]  <= ck_s2_q;
               vld_q[i] <= 1'b1;
            end
         end
      end
   end

   assign wl.fb     = fb_q;
   assign wl.fb_vld = vld_q;
   assign wl.cap    = rise;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_fb_capture: assert property (rise[0] |=> fb_q[0] == $past(ck_s2_q))
      else $error("strobe 0 feedback not the sampled clock");
   a_fb_cap_one: assert property (rise[1] |=> fb_q[1] == $past(ck_s2_q))
      else $error("strobe 1 feedback not the sampled clock");
endmodule : fsp_wl_capture

// ===== bench/fsp_ctl_model.sv
`timescale 1ns/100ps
module fsp_ctl_model (
   // Burst control
   input  wire logic       go,
   input  wire logic       late,
   input  wire logic [1:0] sel,
   // Link pins
   output logic            ck_t,
   output logic [1:0]      dqs_t
);
   // One clock half with an optional strobe pulse 20 ns into it
   task automatic half(input logic lvl, input logic hit);
      ck_t = lvl;
      #20;
      if (hit) dqs_t = sel;
      #30;
      dqs_t = 2'h0;
      #12.5;
   endtask : half

   initial begin
      ck_t  = 1'b0;
      dqs_t = 2'h0;
      forever begin
         // Clock stands still between bursts, so only whole periods run
         wait (go);
         half(1'b1, !late);
         half(1'b0, late);
      end
   end
endmodule : fsp_ctl_model

// ===== bench/freq_set_point_and_write_leveling_tb.sv
`timescale 1ns/100ps
`include "fsp_consts.svh"
module freq_set_point_and_write_leveling_tb;
   import fsp_pkg::*;
   localparam int         LIMIT   = 20000;
   localparam int         WL_WAIT = 500;
   localparam logic [1:0] SELS [3] = '{2'h1, 2'h3, 2'h2};
   localparam logic       LATES [3] = '{1'b0, 1'b1, 1'b0};
   localparam logic [15:0] EXPS [3] = '{16'h00FF, 16'h0000, 16'hFF00};
   logic        clk;
   logic        rst_b;
   fsp_addr_t   aw_addr;
   logic        aw_valid;
   logic [31:0] w_data;
   logic        w_valid;
   logic [3:0]  w_strb;
   fsp_addr_t   ar_addr;
   logic        ar_valid;
   logic        awready;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        go;
   logic        late;
   logic [1:0]  sel;
   logic        ck_t;
   logic [1:0]  dqs_t;
   logic [15:0] dq_o;
   logic [15:0] dq_oe;
   logic        sp_op;
   logic        sp_sw;
   logic        vref_current_mode;
   logic        wl_act;
   logic [1:0]  exp_b [$];
   logic [33:0] exp_r [$];
   int          fails;
   int          samples_checked;
   int          cyc;

   fsp_top i_fsp_top (
      .REF_CLK(clk), .RST_B(rst_b),
      .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
      .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1),
      .CK_T(ck_t), .DQS_T(dqs_t), .DQ_O(dq_o), .DQ_OE(dq_oe),
      .SET_POINT_OPERATING(sp_op), .SET_POINT_SWITCHING(sp_sw),
      .VREF_CURRENT_MODE(vref_current_mode), .WL_ACTIVE(wl_act));

   fsp_ctl_model i_fsp_ctl_model (.go(go), .late(late), .sel(sel), .ck_t(ck_t), .dqs_t(dqs_t));

   always #5 clk = ~clk;

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run

   // Responses are compared where the bus hands them over
   always @(posedge clk) begin
      if (bvalid === 1'b1) chk(34'(bresp), 34'(exp_b.pop_front()));
      if (rvalid === 1'b1) chk({rresp, rdata}, exp_r.pop_front());
      cyc++;
      if (cyc == LIMIT) begin
         fails++;
         complete_run();
      end
   end

   task automatic axi_wr(input fsp_addr_t a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clk);
      exp_b.push_back(r);
      aw_addr  <= a;
      aw_valid <= 1'b1;
      w_data   <= d;
      w_valid  <= 1'b1;
      // Waits end only on the answer or on the bench timeout
      do begin
         @(posedge clk);
         if (awready === 1'b1) aw_valid <= 1'b0;
         if (wready === 1'b1) w_valid <= 1'b0;
      end while (bvalid !== 1'b1);
   endtask : axi_wr

   task automatic rd(input fsp_addr_t a, input logic [33:0] e);
      @(posedge clk);
      exp_r.push_back(e);
      ar_addr  <= a;
      ar_valid <= 1'b1;
      do begin
         @(posedge clk);
      end while (arready !== 1'b1);
      ar_valid <= 1'b0;
      do begin
         @(posedge clk);
      end while (rvalid !== 1'b1);
   endtask : rd

   task automatic mrw(input fsp_ma_t ma, input fsp_byte_t op);
      axi_wr(`FSP_A_MRW, {18'h0, ma, op}, `FSP_RESP_OKAY);
   endtask : mrw

   // Switch the operating copy with the fast reference current, then measure the switch time
   task automatic sw(input logic op, input int n, input fsp_byte_t act);
      int c;
      mrw(`FSP_MA_MODE_REGISTER_THIRTEEN, {op, 7'h08});
      #1;
      chk(34'({sp_sw, vref_current_mode}), 34'h3);
      // Counting starts one edge after the write took effect
      c = 0;
      while (sp_op !== op && c < 40) begin
         @(posedge clk);
         #1;
         c++;
      end
      chk(34'(c), 34'(n - 1));
      rd(`FSP_A_ACTIVE, {26'h0, act});
      mrw(`FSP_MA_MODE_REGISTER_THIRTEEN, {op, 7'h00});
   endtask : sw

   initial begin
      fsp_byte_t rv;
      clk = 1'b0;
      rst_b = 1'b0;
      aw_addr = '0;
      aw_valid = 1'b0;
      w_data = '0;
      w_valid = 1'b0;
      w_strb = 4'hF;
      ar_addr = '0;
      ar_valid = 1'b0;
      go = 1'b0;
      late = 1'b0;
      sel = 2'h0;
      fails = 0;
      samples_checked = 0;
      cyc = 0;
      rv = 8'($urandom(38232));
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      chk(34'({sp_op, sp_sw, vref_current_mode, wl_act}), 34'h0);
      chk(34'({dq_oe, dq_o}), 34'h0);
      rd(`FSP_A_STATUS, 34'h0);
      rd(`FSP_A_ACTIVE, 34'h4D);
      mrw(`FSP_MA_MODE_REGISTER_THIRTEEN, 8'h40);
      mrw(`FSP_MA_MODE_REGISTER_TWELVE, 8'h4E);
      mrw(`FSP_MA_MR3, rv);
      axi_wr(`FSP_A_MRR_SEL, 32'h03, `FSP_RESP_OKAY);
      rd(`FSP_A_MRR_DATA, {26'h0, rv});
      mrw(`FSP_MA_MODE_REGISTER_THIRTEEN, 8'h00);
      axi_wr(`FSP_A_MRR_SEL, 32'h0C, `FSP_RESP_OKAY);
      rd(`FSP_A_MRR_DATA, 34'h4D);
      rd(`FSP_A_ACTIVE, 34'h4D);
      sw(1'b1, `FSP_TFC_SHORT_CYC, 8'h4E);
      mrw(`FSP_MA_MODE_REGISTER_TWELVE, 8'h0D);
      rd(`FSP_A_ACTIVE, 34'h4E);
      sw(1'b0, `FSP_TFC_LONG_CYC, 8'h0D);
      mrw(`FSP_MA_MODE_REGISTER_THIRTEEN, 8'h40);
      mrw(`FSP_MA_MODE_REGISTER_TWELVE, 8'h10);
      sw(1'b1, `FSP_TFC_MID_CYC, 8'h10);
      // Only the low byte enabled: the command reuses the last mode-register address
      w_strb <= 4'h1;
      axi_wr(`FSP_A_MRW, {18'h0, `FSP_MA_MODE_REGISTER_TWELVE, 8'hC0}, `FSP_RESP_OKAY);
      w_strb <= 4'hF;
      rd(`FSP_A_MRR_DATA, 34'h10);
      // Unmapped words answer with an error and read as zero
      axi_wr(5'h14, 32'h0, `FSP_RESP_SLVERR);
      rd(5'h1C, {`FSP_RESP_SLVERR, 32'h0});
      mrw(`FSP_MA_MR2, 8'h80);
      #1;
      chk(34'({wl_act, dq_oe}), 34'h1FFFF);
      repeat (WL_WAIT) @(posedge clk);
      for (int i = 0; i < 3; i++) begin
         late <= LATES[i];
         sel  <= SELS[i];
         go   <= 1'b1;
         repeat (40) @(posedge clk);
         go <= 1'b0;
         repeat (30) @(posedge clk);
         #1;
         chk(34'(dq_o), 34'(EXPS[i]));
      end
      mrw(`FSP_MA_MR2, 8'h00);
      #1;
      chk(34'({wl_act, dq_oe, dq_o}), 34'h0);
      // A reset in mid-run brings operation back to copy 0
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      chk(34'({sp_op, sp_sw, vref_current_mode, wl_act}), 34'h0);
      rd(`FSP_A_ACTIVE, 34'h4D);
      complete_run();
   end
endmodule : freq_set_point_and_write_leveling_tb
